// [rtl/mie_exec.sv]
// Purpose: Executes a subset of an 8-bit core's instructions issued over APB
// Assumes: Single clock pclk at 125 MHz; APB3 slave; instruction written to INSTR
// Notes:   Instruction issue and register access share the one APB port
`include "mie_map.svh"
`default_nettype none
module mie_exec (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Oscillator control
    output var  logic        osc_halt
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic mie_pkg::mie_kind_e decode(input logic [11:0] w);
        if (w == `MIE_OP_NOP)
            return mie_pkg::k_nop;
        if (w == `MIE_OP_OPTION)
            return mie_pkg::k_option;
        if (w == `MIE_OP_SLEEP)
            return mie_pkg::k_sleep;
        if (w[11:6] == `MIE_OP_SUB)
            return mie_pkg::k_sub;
        if (w[11:6] == `MIE_OP_ROTL)
            return mie_pkg::k_rotl;
        if (w[11:8] == `MIE_OP_LDLIT)
            return mie_pkg::k_ldlit;
        if (w[11:8] == `MIE_OP_RETLIT)
            return mie_pkg::k_retlit;
        return mie_pkg::k_other;
    endfunction : decode

    mie_pkg::mie_state_e state;
    mie_pkg::mie_kind_e  kind;
    logic [11:0] ir;
    logic [7:0]  acc;
    logic [7:0]  option;
    logic        flag_c;
    logic        digit_carry_flag;
    logic        flag_z;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic        pin_change_wake_flag;
    logic [10:0] stack_top;
    logic [10:0] pc;
    logic [7:0]  wdog_pre;
    logic [7:0]  watchdog_counter;
    logic [7:0]  file_mem [32];
    logic [4:0]  faddr;
    logic        dest;
    logic [7:0]  lit;
    logic [7:0]  fval;
    logic [8:0]  diff;
    logic [4:0]  ndiff;
    logic [7:0]  rot;
    logic        exec;
    logic        bus_ok;
    logic        wr_en;
    logic [31:0] next_prdata;
    logic        next_err;
    logic [7:0]  status;

    assign kind  = decode(ir);
    assign faddr = ir[4:0];
    assign dest  = ir[`MIE_DEST_BIT];
    assign lit   = ir[7:0];
    assign fval  = file_mem[faddr];
    assign exec  = (state == mie_pkg::st_exec);
    // Borrow-free subtract: carry set means no borrow
    assign diff  = {1'b0, fval} - {1'b0, acc};
    assign ndiff = {1'b0, fval[3:0]} - {1'b0, acc[3:0]};
    assign rot   = {fval[6:0], flag_c};
    always_comb begin
        status = 8'h00;
        status[`MIE_ST_C]    = flag_c;
        status[`MIE_ST_DIGC] = digit_carry_flag;
        status[`MIE_ST_Z]    = flag_z;
        status[`MIE_ST_DOWN] = powerdown_flag;
        status[`MIE_ST_TOUT] = timeout_flag;
        status[`MIE_ST_WAKE] = pin_change_wake_flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: pready is held low while an instruction is in flight, so
    // software never races the execution unit on the same registers.
    assign bus_ok = (state == mie_pkg::st_idle) || (state == mie_pkg::st_asleep);
    assign wr_en  = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
            next_err = 1'b1;
        end else if (paddr[7]) begin
            next_prdata = {24'h00_0000, file_mem[paddr[6:2]]};
        end else begin
            case (paddr[7:0])
                `MIE_OFF_INSTR: begin
                    next_prdata = {20'h0_0000, ir};
                    // A sleeping core fetches nothing
                    next_err    = pwrite & (state == mie_pkg::st_asleep);
                end
                `MIE_OFF_ACC:    next_prdata = {24'h00_0000, acc};
                `MIE_OFF_OPTION: next_prdata = {24'h00_0000, option};
                `MIE_OFF_STATUS: next_prdata = {24'h00_0000, status};
                `MIE_OFF_STACK:  next_prdata = {21'h00_0000, stack_top};
                `MIE_OFF_PC:     next_prdata = {21'h00_0000, pc};
                `MIE_OFF_WDOG:   next_prdata = {16'h0000, watchdog_counter, wdog_pre};
                `MIE_OFF_CTRL:   next_prdata = 32'h0000_0000;
                `MIE_OFF_STATE:  next_prdata = {28'h000_0000, state};
                default:         next_err    = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready && bus_ok) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= mie_pkg::st_idle;
            ir    <= `MIE_OP_NOP;
        end else begin
            unique case (state)
                mie_pkg::st_idle: begin
                    if (wr_en && paddr[7:0] == `MIE_OFF_INSTR) begin
                        ir    <= pwdata[11:0];
                        state <= mie_pkg::st_exec;
                    end
                end
                mie_pkg::st_exec: begin
                    if (kind == mie_pkg::k_retlit)
                        state <= mie_pkg::st_second;
                    else if (kind == mie_pkg::k_sleep)
                        state <= mie_pkg::st_asleep;
                    else
                        state <= mie_pkg::st_idle;
                end
                mie_pkg::st_second: state <= mie_pkg::st_idle;
                mie_pkg::st_asleep: begin
                    if (wr_en && paddr[7:0] == `MIE_OFF_CTRL && pwdata[`MIE_CTRL_WAKE])
                        state <= mie_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            osc_halt <= 1'b0;
        else if (exec && kind == mie_pkg::k_sleep)
            osc_halt <= 1'b1;
        else if (wr_en && paddr[7:0] == `MIE_OFF_CTRL && pwdata[`MIE_CTRL_WAKE])
            osc_halt <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator and option register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= `MIE_RST_ACC;
        end else if (exec) begin
            if (kind == mie_pkg::k_ldlit || kind == mie_pkg::k_retlit)
                acc <= lit;
            else if (kind == mie_pkg::k_sub && !dest)
                acc <= diff[7:0];
            else if (kind == mie_pkg::k_rotl && !dest)
                acc <= rot;
        end else if (wr_en && paddr[7:0] == `MIE_OFF_ACC) begin
            acc <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            option <= `MIE_RST_OPTION;
        else if (exec && kind == mie_pkg::k_option)
            option <= acc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags; software may write the arithmetic and wake bits only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_c               <= 1'b0;
            digit_carry_flag     <= 1'b0;
            flag_z               <= 1'b0;
            pin_change_wake_flag <= 1'b0;
        end else if (exec) begin
            if (kind == mie_pkg::k_sub) begin
                flag_c           <= ~diff[8];
                digit_carry_flag <= ~ndiff[4];
                flag_z           <= (diff[7:0] == 8'h00);
            end else if (kind == mie_pkg::k_rotl) begin
                flag_c <= fval[7];
            end
        end else if (wr_en && paddr[7:0] == `MIE_OFF_STATUS) begin
            flag_c               <= pwdata[`MIE_ST_C];
            digit_carry_flag     <= pwdata[`MIE_ST_DIGC];
            flag_z               <= pwdata[`MIE_ST_Z];
            pin_change_wake_flag <= pwdata[`MIE_ST_WAKE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (exec && kind == mie_pkg::k_sleep) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // File registers hold data only, so they carry no reset
    always_ff @(posedge pclk) begin
        if (exec && dest && (kind == mie_pkg::k_sub || kind == mie_pkg::k_rotl))
            file_mem[faddr] <= (kind == mie_pkg::k_sub) ? diff[7:0] : rot;
        else if (wr_en && paddr[11:7] == 5'h01)
            file_mem[paddr[6:2]] <= pwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and return address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pc <= `MIE_RST_PC;
        else if (exec && kind == mie_pkg::k_retlit)
            pc <= stack_top;
        else if (exec)
            pc <= pc + 11'h001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stack_top <= `MIE_RST_STACK;
        else if (wr_en && paddr[7:0] == `MIE_OFF_STACK)
            stack_top <= pwdata[10:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: frozen while the oscillator is halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_pre         <= 8'h00;
            watchdog_counter <= 8'h00;
        end else if (exec && kind == mie_pkg::k_sleep) begin
            wdog_pre         <= 8'h00;
            watchdog_counter <= 8'h00;
        end else if (!osc_halt) begin
            wdog_pre <= wdog_pre + 8'h01;
            if (wdog_pre == 8'hff)
                watchdog_counter <= watchdog_counter + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fire(mie_pkg::mie_kind_e k);
        exec && kind == k;
    endsequence

    sequence s_flags_held;
        $stable(flag_c) && $stable(digit_carry_flag) && $stable(flag_z);
    endsequence

    a_ldlit_acc_load: assert property (
        s_fire(mie_pkg::k_ldlit) |=> acc == $past(lit) ##0 s_flags_held)
        else $error("literal load did not set accumulator");

    a_option_copy: assert property (
        s_fire(mie_pkg::k_option) |=> option == $past(acc) ##0 s_flags_held)
        else $error("option load wrong");

    a_retlit_load: assert property (
        s_fire(mie_pkg::k_retlit) |=> acc == $past(lit) && pc == $past(stack_top))
        else $error("return with literal wrong");

    a_retlit_two_cycles: assert property (
        s_fire(mie_pkg::k_retlit) |=> state == mie_pkg::st_second
            ##1 state == mie_pkg::st_idle)
        else $error("return with literal not two cycles");

    a_sleep_wdog_clear: assert property (
        s_fire(mie_pkg::k_sleep) |=> watchdog_counter == 8'h00 && wdog_pre == 8'h00)
        else $error("sleep did not clear watchdog");

    a_sleep_flag_set: assert property (
        s_fire(mie_pkg::k_sleep) |=> timeout_flag && !powerdown_flag
            && $stable(pin_change_wake_flag))
        else $error("sleep flags wrong");

    a_sleep_osc_halt: assert property (
        s_fire(mie_pkg::k_sleep) |=> osc_halt && state == mie_pkg::st_asleep
            ##1 $stable(watchdog_counter) && $stable(wdog_pre))
        else $error("sleep did not halt oscillator");

    a_rotl_file_dest: assert property (
        s_fire(mie_pkg::k_rotl) ##0 dest |=> file_mem[$past(faddr)]
            == {$past(fval[6:0]), $past(flag_c)} && flag_c == $past(fval[7])
            && $stable(flag_z) && $stable(digit_carry_flag) && $stable(acc))
        else $error("rotate into file wrong");

    a_sub_flag_calc: assert property (
        s_fire(mie_pkg::k_sub) |=> flag_c == ($past(fval) >= $past(acc))
            && digit_carry_flag == ($past(fval[3:0]) >= $past(acc[3:0]))
            && flag_z == ($past(fval) == $past(acc)))
        else $error("subtract flags wrong");

    a_sub_dest_route: assert property (
        s_fire(mie_pkg::k_sub) |=> (!$past(dest) && acc == $past(diff[7:0]))
            || ($past(dest) && file_mem[$past(faddr)] == $past(diff[7:0])
            && $stable(acc)))
        else $error("subtract destination wrong");

    a_rotl_acc_dest: assert property (
        s_fire(mie_pkg::k_rotl) ##0 !dest |=> acc == {$past(fval[6:0]), $past(flag_c)}
            && file_mem[$past(faddr)] == $past(fval))
        else $error("rotate into accumulator wrong");

    a_nop_no_change: assert property (
        s_fire(mie_pkg::k_nop) |=> state == mie_pkg::st_idle && $stable(acc)
            && $stable(option) && $stable(status) && file_mem[$past(faddr)] == $past(fval))
        else $error("no-operation changed state");

endmodule : mie_exec
`default_nettype wire

// [rtl/mie_map.svh]
// Purpose: Offsets, field positions, reset values and opcode patterns
// Assumes: APB byte addresses, 32-bit words, 12-bit instruction words
// Notes:   Definitions only
`ifndef MIE_MAP_SVH
`define MIE_MAP_SVH
// Register byte offsets
`define MIE_OFF_INSTR   8'h00
`define MIE_OFF_ACC     8'h04
`define MIE_OFF_OPTION  8'h08
`define MIE_OFF_STATUS  8'h0c
`define MIE_OFF_STACK   8'h10
`define MIE_OFF_PC      8'h14
`define MIE_OFF_WDOG    8'h18
`define MIE_OFF_CTRL    8'h1c
`define MIE_OFF_STATE   8'h20
// Status and control bit positions
`define MIE_ST_C        0
`define MIE_ST_DIGC     1
`define MIE_ST_Z        2
`define MIE_ST_DOWN     3
`define MIE_ST_TOUT     4
`define MIE_ST_WAKE     7
`define MIE_CTRL_WAKE   0
// Reset values
`define MIE_RST_ACC     8'h00
`define MIE_RST_OPTION  8'hff
`define MIE_RST_PC      11'h000
`define MIE_RST_STACK   11'h000
// Instruction patterns
`define MIE_OP_NOP      12'h000
`define MIE_OP_OPTION   12'h002
`define MIE_OP_SLEEP    12'h003
`define MIE_OP_SUB      6'h02
`define MIE_OP_ROTL     6'h0d
`define MIE_OP_LDLIT    4'hc
`define MIE_OP_RETLIT   4'h8
`define MIE_DEST_BIT    5
`endif

// [rtl/mie_pkg.sv]
// Purpose: Types shared by the instruction execution block
// Assumes: Nothing
// Notes:   One-hot sequencer states
`default_nettype none
package mie_pkg;
    typedef enum logic [3:0] {
        st_idle   = 4'b0001,
        st_exec   = 4'b0010,
        st_second = 4'b0100,
        st_asleep = 4'b1000
    } mie_state_e;
    typedef enum logic [2:0] {
        k_nop, k_option, k_sleep, k_sub, k_rotl, k_ldlit, k_retlit, k_other
    } mie_kind_e;
endpackage : mie_pkg
`default_nettype wire

// [verif/mie_fetch_model.sv]
// Purpose: Fetch-side model that issues instruction and register transfers over APB
// Assumes: Every call starts just after a rising edge of pclk
// Notes:   Keeps psel up between calls so transfers can run back to back
`default_nettype none
module mie_fetch_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Access-phase length of the last transfer, in cycles
    int acc_cycles;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // No fixed latency assumed: the access phase lasts until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable    <= 1'b1;
        acc_cycles = 0;
        do begin
            @(posedge pclk);
            acc_cycles++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
    endtask : xfer

    // Released lines show the inverse so stale values are never trusted
    task automatic rest();
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask : rest
endmodule : mie_fetch_model
`default_nettype wire

// [verif/tb_mcu_instr_exec_subset.sv]
// Purpose: Self-checking bench for the instruction execution block
// Assumes: Transfers issued back to back through the fetch model
// Notes:   Expected values come from the instruction semantics only
`include "mie_map.svh"
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) begin \
            num_errors++; \
            $display("wrong value %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_mcu_instr_exec_subset;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_halt;
    logic        last_err;
    logic [31:0] rdv;
    logic [10:0] exp_pc;
    logic [7:0]  fv;
    logic [7:0]  av;
    logic [7:0]  res;
    logic [4:0]  idx;
    logic [11:0] fa;
    int          num_errors = 0;
    int          tests_run  = 0;
    logic [7:0]  lits [3] = '{8'h00, 8'hff, 8'h5a};
    logic [15:0] subs [4] = '{16'h3512, 16'h1235, 16'h4444, 16'h1001};

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    mie_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_halt(osc_halt));

    mie_fetch_model u_fetch (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] unused;
        u_fetch.xfer(1'b1, a, d, unused, last_err);
    endtask : wr

    task automatic expect_reg(input string nm, input logic [11:0] a, input logic [31:0] ex);
        u_fetch.xfer(1'b0, a, 32'h0000_0000, rdv, last_err);
        `CHK(nm, ex, rdv)
    endtask : expect_reg

    task automatic exec(input logic [11:0] op);
        wr(`MIE_OFF_INSTR, {20'h00000, op});
        exp_pc = exp_pc + 11'h001;
    endtask : exec

    task automatic end_test(input string nm);
        $display("test %s done, %0d checks so far", nm, tests_run);
    endtask : end_test

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    // Generous bound: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        finish_test();
    end

    initial begin
        presetn <= 1'b0;
        exp_pc  = 11'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        expect_reg("acc", `MIE_OFF_ACC, 32'h0000_0000);
        expect_reg("option", `MIE_OFF_OPTION, 32'h0000_00ff);
        expect_reg("status", `MIE_OFF_STATUS, 32'h0000_0018);
        expect_reg("state", `MIE_OFF_STATE, 32'h0000_0001);
        expect_reg("unmapped", 12'h024, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, last_err)
        expect_reg("misaligned", 12'h006, 32'h0000_0000);
        `CHK("misaligned err", 1'b1, last_err)
        end_test("reset");

        wr(`MIE_OFF_STATUS, 32'h0000_0087);
        foreach (lits[i]) begin
            exec({4'hc, lits[i]});
            expect_reg("acc", `MIE_OFF_ACC, {24'h0, lits[i]});
            expect_reg("status", `MIE_OFF_STATUS, 32'h0000_009f);
        end
        exec(`MIE_OP_OPTION);
        expect_reg("option", `MIE_OFF_OPTION, 32'h0000_005a);
        expect_reg("status", `MIE_OFF_STATUS, 32'h0000_009f);
        end_test("literal and option");

        wr(12'h080, 32'h0000_0077);
        exec(`MIE_OP_NOP);
        expect_reg("acc", `MIE_OFF_ACC, 32'h0000_005a);
        `CHK("nop cycles", 2, u_fetch.acc_cycles)
        expect_reg("file", 12'h080, 32'h0000_0077);
        expect_reg("option", `MIE_OFF_OPTION, 32'h0000_005a);
        expect_reg("status", `MIE_OFF_STATUS, 32'h0000_009f);
        expect_reg("pc", `MIE_OFF_PC, {21'h0, exp_pc});
        // Undefined words run as a no-operation that still advances pc
        exec(12'hfff);
        expect_reg("undef acc", `MIE_OFF_ACC, 32'h0000_005a);
        expect_reg("undef status", `MIE_OFF_STATUS, 32'h0000_009f);
        expect_reg("undef pc", `MIE_OFF_PC, {21'h0, exp_pc});
        end_test("no operation");

        wr(`MIE_OFF_STACK, 32'h0000_0123);
        exec({4'h8, 8'ha5});
        expect_reg("acc", `MIE_OFF_ACC, 32'h0000_00a5);
        `CHK("return cycles", 3, u_fetch.acc_cycles)
        exp_pc = 11'h123;
        expect_reg("pc", `MIE_OFF_PC, {21'h0, exp_pc});
        end_test("return");

        for (int c = 0; c < 2; c++) begin
            for (int d = 0; d < 2; d++) begin
                idx = d[0] ? 5'd31 : 5'd0;
                fa  = {5'b00001, idx, 2'b00};
                fv  = c[0] ? 8'h69 : 8'h96;
                res = {fv[6:0], c[0]};
                wr(`MIE_OFF_STATUS, {24'h0, 7'h43, c[0]});
                wr(`MIE_OFF_ACC, 32'h0000_003c);
                wr(fa, {24'h0, fv});
                exec({6'h0d, d[0], idx});
                expect_reg("rot dest", d[0] ? fa : `MIE_OFF_ACC, {24'h0, res});
                expect_reg("rot keep", d[0] ? `MIE_OFF_ACC : fa,
                           d[0] ? 32'h3c : {24'h0, fv});
                expect_reg("status", `MIE_OFF_STATUS, {24'h0, 7'h4f, fv[7]});
            end
        end
        end_test("rotate");

        foreach (subs[i]) begin
            for (int d = 0; d < 2; d++) begin
                fv  = subs[i][15:8];
                av  = subs[i][7:0];
                res = fv - av;
                wr(`MIE_OFF_STATUS, 32'h0000_0080);
                wr(`MIE_OFF_ACC, {24'h0, av});
                wr(12'h0c4, {24'h0, fv});
                exec({`MIE_OP_SUB, d[0], 5'd17});
                expect_reg("sub dest", d[0] ? 12'h0c4 : `MIE_OFF_ACC, {24'h0, res});
                expect_reg("sub keep", d[0] ? `MIE_OFF_ACC : 12'h0c4,
                           {24'h0, d[0] ? av : fv});
                expect_reg("status", `MIE_OFF_STATUS,
                           {24'h0, 5'h13, res == 8'h00, fv[3:0] >= av[3:0], fv >= av});
            end
        end
        end_test("subtract");

        wr(`MIE_OFF_STATUS, 32'h0000_0085);
        exec(`MIE_OP_SLEEP);
        expect_reg("status", `MIE_OFF_STATUS, 32'h0000_0095);
        expect_reg("watchdog", `MIE_OFF_WDOG, 32'h0000_0000);
        expect_reg("state", `MIE_OFF_STATE, 32'h0000_0008);
        `CHK("osc halt", 1'b1, osc_halt)
        wr(`MIE_OFF_INSTR, {20'h00000, `MIE_OP_NOP});
        `CHK("asleep instr err", 1'b1, last_err)
        wr(`MIE_OFF_CTRL, 32'h0000_0001);
        expect_reg("state", `MIE_OFF_STATE, 32'h0000_0001);
        `CHK("osc run", 1'b0, osc_halt)
        expect_reg("pc", `MIE_OFF_PC, {21'h0, exp_pc});
        end_test("sleep");
        u_fetch.rest();
        finish_test();
    end
endmodule : tb_mcu_instr_exec_subset
`default_nettype wire
